/* File: design/status_flag_update.sv */
// Status flag update: overflow, user flag, parity and bank select
//
// Functional notes
// RL1: Add, add-with-carry and subtract-with-borrow set overflow on sign overflow.
// RL2: Multiply sets overflow when the product exceeds 255.
// RL3: Divide sets overflow when the divisor is zero.
// RL4: Those five operations clear overflow when no overflow case occurs.
// RL5: The user flag changes only by software writes, never by hardware.
// RL6: Parity is one when the accumulator holds an odd count of ones.
// RL7: Two bank bits pick one of four eight-register banks (10->0x10, 11->0x18).
`timescale 1ns/1ps
module status_flag_update (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Execution datapath
    input wire logic opValid,
    input status_flag_pkg::op_type opCode,
    input wire logic [7:0] opA,
    input wire logic [7:0] opB,
    input wire logic carryIn,
    input wire logic [status_flag_pkg::ACC_WIDTH-1:0] accumulator,
    // Flag outputs
    output logic overflowFlag,
    output logic userFlagOne,
    output logic parityFlag,
    output logic bankSelectHigh,
    output logic bankSelectLow,
    output logic [4:0] bankBase,
    output logic [7:0] statusWord,
    output logic [7:0] opResult
);
    import status_flag_pkg::*;

    typedef struct packed {
        logic ack;
        logic [31:0] readData;
        logic overflow;
        logic userFlag;
        logic [1:0] bankSel;
        logic parity;
        logic [7:0] lastResult;
    } state_type;

    state_type state;
    state_type next_state;

    logic accParity;
    logic busReq;
    logic flagsHit;
    logic resultHit;
    logic flagsWrite;
    logic carryUsed;
    logic borrowUsed;
    logic [8:0] addSum;
    logic [8:0] subDiff;
    logic [15:0] product;
    logic [7:0] quotient;
    logic addOverflow;
    logic subOverflow;
    logic mulTooBig;
    logic divByZero;
    logic opKnown;
    logic opOverflow;
    logic [7:0] opValue;
    logic [7:0] flagsView;

    // Parity of the live accumulator
    parity_tree u_parity (
        .dataIn(accumulator),
        .oddParity(accParity)
    );

    // Bus decode
    assign busReq = cyc_i & stb_i;
    assign flagsHit = (adr_i == STATUS_FLAGS_OFFSET);
    assign resultHit = (adr_i == LAST_RESULT_OFFSET);
    assign flagsWrite = busReq & state.ack & we_i & sel_i[0] & flagsHit;

    // Raw arithmetic results
    assign carryUsed = (opCode == ADD_WITH_CARRY_OP) & carryIn;
    assign borrowUsed = (opCode == SUBTRACT_WITH_BORROW_OP) & carryIn;
    assign addSum = {1'b0, opA} + {1'b0, opB} + {8'h00, carryUsed};
    assign subDiff = {1'b0, opA} - {1'b0, opB} - {8'h00, borrowUsed};
    assign product = {8'h00, opA} * {8'h00, opB};
    assign divByZero = (opB == ZERO_BYTE);
    assign quotient = divByZero ? ZERO_BYTE : opA / opB;

    // RL1: signed overflow detect
    assign addOverflow = (opA[SIGN_BIT] == opB[SIGN_BIT]) &&
        (addSum[SIGN_BIT] != opA[SIGN_BIT]);
    assign subOverflow = (opA[SIGN_BIT] != opB[SIGN_BIT]) &&
        (subDiff[SIGN_BIT] != opA[SIGN_BIT]);
    // RL2: product beyond one byte
    assign mulTooBig = (product > BYTE_MAX);

    // Per-operation overflow and result select
    always_comb begin
        opKnown = 1'b1;
        opOverflow = 1'b0;
        opValue = ZERO_BYTE;
        case (opCode)
            ADD_OP, ADD_WITH_CARRY_OP: begin
                opOverflow = addOverflow;
                opValue = addSum[7:0];
            end
            SUBTRACT_WITH_BORROW_OP: begin
                opOverflow = subOverflow;
                opValue = subDiff[7:0];
            end
            MULTIPLY_OP: begin
                opOverflow = mulTooBig;
                opValue = product[7:0];
            end
            // RL3: zero divisor flags overflow
            DIVIDE_OP: begin
                opOverflow = divByZero;
                opValue = quotient;
            end
            default: begin
                opKnown = 1'b0;
            end
        endcase
    end

    // Software view of the status flags
    always_comb begin
        flagsView = ZERO_BYTE;
        flagsView[PARITY_BIT] = state.parity;
        flagsView[USER_FLAG_BIT] = state.userFlag;
        flagsView[OVERFLOW_BIT] = state.overflow;
        flagsView[BANK_LOW_BIT] = state.bankSel[0];
        flagsView[BANK_HIGH_BIT] = state.bankSel[1];
    end

    // Next state
    always_comb begin
        next_state = state;
        // One-cycle ack, dropped after it is given
        next_state.ack = busReq & ~state.ack;
        if (busReq & ~state.ack) begin
            if (flagsHit) begin
                next_state.readData = {24'h00_0000, flagsView};
            end else if (resultHit) begin
                next_state.readData = {24'h00_0000, state.lastResult};
            end else begin
                next_state.readData = ZERO_WORD;
            end
        end
        // RL5: user flag only from a software write
        if (flagsWrite) begin
            next_state.userFlag = dat_i[USER_FLAG_BIT];
            next_state.overflow = dat_i[OVERFLOW_BIT];
            next_state.bankSel = {dat_i[BANK_HIGH_BIT], dat_i[BANK_LOW_BIT]};
        end
        // RL4: operation result sets or clears overflow
        if (opValid & opKnown) begin
            next_state.overflow = opOverflow;
            next_state.lastResult = opValue;
        end
        // RL6: parity follows the accumulator
        next_state.parity = accParity;
    end

    // State register
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state.ack <= 1'b0;
            state.readData <= ZERO_WORD;
            state.overflow <= STATUS_RESET[OVERFLOW_BIT];
            state.userFlag <= STATUS_RESET[USER_FLAG_BIT];
            state.bankSel <= {STATUS_RESET[BANK_HIGH_BIT],
                STATUS_RESET[BANK_LOW_BIT]};
            state.parity <= STATUS_RESET[PARITY_BIT];
            state.lastResult <= RESULT_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Outputs
    assign ack_o = state.ack;
    assign dat_o = state.readData;
    assign overflowFlag = state.overflow;
    assign userFlagOne = state.userFlag;
    assign parityFlag = state.parity;
    assign bankSelectHigh = state.bankSel[1];
    assign bankSelectLow = state.bankSel[0];
    // RL7: bank base address from the select bits
    assign bankBase = {state.bankSel, BANK_BASE_PAD};
    assign statusWord = flagsView;
    assign opResult = state.lastResult;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // RL1: add sign overflow sets the flag
    a_add_sign_set: // RL1
    assert property (opValid && opCode == ADD_OP &&
        opA[7] == opB[7] && opA[7] != 8'(opA + opB) >> 7
        |=> overflowFlag)
    else $error("add sign overflow did not set overflow");

    // RL1: subtract sign overflow sets the flag
    a_sub_sign_set: // RL1
    assert property (opValid && opCode == SUBTRACT_WITH_BORROW_OP &&
        !carryIn && opA[7] != opB[7] &&
        opA[7] != 8'(opA - opB) >> 7
        |=> overflowFlag)
    else $error("subtract sign overflow did not set overflow");

    // RL2: large product sets the flag
    a_mul_big_set: // RL2
    assert property (opValid && opCode == MULTIPLY_OP &&
        ({8'h00, opA} * {8'h00, opB}) > 16'h00FF |=> overflowFlag)
    else $error("large product did not set overflow");

    // RL3: zero divisor sets the flag
    a_div_zero_set: // RL3
    assert property (opValid && opCode == DIVIDE_OP && opB == 8'h00
        |=> overflowFlag)
    else $error("zero divisor did not set overflow");

    // RL4: small product or good divide clears the flag
    a_no_fault_clear: // RL4
    assert property (opValid && ((opCode == MULTIPLY_OP &&
        ({8'h00, opA} * {8'h00, opB}) <= 16'h00FF) ||
        (opCode == DIVIDE_OP && opB != 8'h00)) |=> !overflowFlag)
    else $error("overflow not cleared without fault");

    // RL5: user flag steady without a write
    a_user_flag_hold: // RL5
    assert property (!flagsWrite |=> $stable(userFlagOne))
    else $error("user flag changed without software write");

    // RL6: parity tracks the previous accumulator
    a_parity_track: // RL6
    assert property ($past(reset_n) |->
        parityFlag == ^$past(accumulator))
    else $error("parity does not match accumulator");

    // RL7: upper two banks set base bit 4, and bank 11 sits at 0x18
    a_bank_upper: // RL7
    assert property ((bankSelectHigh |-> bankBase[4]) and
        ({bankSelectHigh, bankSelectLow} == 2'b11 |-> bankBase == 5'h18))
    else $error("bank base does not follow select bits");

    // RL7: bank bits move only on a software write
    a_bank_hold: // RL7
    assert property (!flagsWrite |=>
        $stable({bankSelectHigh, bankSelectLow}))
    else $error("bank select changed without software write");

    // RL4: add without sign overflow clears the flag
    a_add_no_ovf: // RL4
    assert property (opValid && opCode == ADD_OP &&
        !(opA[7] == opB[7] && opA[7] != 8'(opA + opB) >> 7)
        |=> !overflowFlag)
    else $error("add without overflow did not clear overflow");

    // Bus ack lasts one cycle
    a_ack_single:
    assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
endmodule

/* File: design/status_flag_pkg.sv */
// Shared constants and types for the status flag update block
package status_flag_pkg;
    // Register byte addresses on the bus
    localparam logic [7:0] STATUS_FLAGS_OFFSET = 8'h00;
    localparam logic [7:0] LAST_RESULT_OFFSET = 8'h04;
    // Field positions within the status flag register
    localparam int PARITY_BIT = 0;
    localparam int USER_FLAG_BIT = 1;
    localparam int OVERFLOW_BIT = 2;
    localparam int BANK_LOW_BIT = 3;
    localparam int BANK_HIGH_BIT = 4;
    // Widths and values
    localparam int ACC_WIDTH = 8;
    localparam int SIGN_BIT = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [15:0] BYTE_MAX = 16'h00FF;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [2:0] BANK_BASE_PAD = 3'h0;
    // Arithmetic operations reported by the execution datapath
    typedef enum logic [2:0] {
        NO_OP,
        ADD_OP,
        ADD_WITH_CARRY_OP,
        SUBTRACT_WITH_BORROW_OP,
        MULTIPLY_OP,
        DIVIDE_OP
    } op_type;
endpackage

/* File: design/parity_tree.sv */
// Odd parity of the accumulator byte
`timescale 1ns/1ps
module parity_tree (
    // Data in
    input wire logic [status_flag_pkg::ACC_WIDTH-1:0] dataIn,
    // Parity out
    output logic oddParity
);
    import status_flag_pkg::*;

    logic [ACC_WIDTH:0] chain;

    // Running exclusive-or over every bit
    assign chain[0] = 1'b0;
    for (genvar i = 0; i < ACC_WIDTH; i++) begin : g_bit
        assign chain[i+1] = chain[i] ^ dataIn[i];
    end
    assign oddParity = chain[ACC_WIDTH];
endmodule

/* File: bench/datapath_model.sv */
// Behavioural model of the execution datapath that feeds the flag block
`timescale 1ns/1ps
module datapath_model (
    // Clock
    input wire logic clk,
    // Operation report
    output logic opValid,
    output status_flag_pkg::op_type opCode,
    output logic [7:0] opA,
    output logic [7:0] opB,
    output logic carryIn,
    // Live accumulator
    output logic [7:0] accumulator
);
    import status_flag_pkg::*;
    // Idle values at time zero
    initial begin
        opValid = 1'b0;
        opCode = NO_OP;
        opA = 8'h00;
        opB = 8'h00;
        carryIn = 1'b0;
        accumulator = 8'h00;
    end
    // One-cycle report; stale operands are scrambled, never held
    task automatic issue(input op_type code, input logic [7:0] a,
                         input logic [7:0] b, input logic c);
        @(posedge clk);
        opValid <= 1'b1;
        opCode <= code;
        opA <= a;
        opB <= b;
        carryIn <= c;
        @(posedge clk);
        opValid <= 1'b0;
        opA <= ~a;
        opB <= ~b;
        carryIn <= ~c;
    endtask
    // New accumulator value right after an edge
    task automatic setAcc(input logic [7:0] v);
        @(posedge clk);
        accumulator <= v;
    endtask
endmodule

/* File: bench/tb.sv */
// Self-checking bench for the status flag update block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin totalChecks++; if ((got) !== (ex)) begin \
    numErrors++; $display("MISMATCH %s expected %h seen %h", nm, ex, got); \
    end end
module tb;
    import status_flag_pkg::*;
    logic clk = 1'b0;
    logic resetN = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] datW = 32'h0000_0000;
    logic [31:0] datR, rd;
    logic ack, opValid, carryIn, ovf, usr, par, bHi, bLo, expOv;
    op_type opCode;
    logic [7:0] opA, opB, acc, word, res;
    logic [4:0] bankBase;
    int numErrors = 0;
    int totalChecks = 0;
    int cycles = 0;
    op_type tCode[10] = '{ADD_OP, NO_OP, ADD_OP, ADD_WITH_CARRY_OP,
        SUBTRACT_WITH_BORROW_OP, SUBTRACT_WITH_BORROW_OP, MULTIPLY_OP,
        MULTIPLY_OP, DIVIDE_OP, DIVIDE_OP};
    logic [7:0] tA[10] = '{8'h7F, 8'h00, 8'h01, 8'h7F, 8'h80, 8'h05, 8'h20,
        8'h0F, 8'h0A, 8'h0A};
    logic [7:0] tB[10] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h01, 8'h01, 8'h10,
        8'h11, 8'h00, 8'h02};
    logic tC[10] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0,
        1'b0};
    logic [7:0] tR[10] = '{8'h80, 8'h80, 8'h02, 8'h80, 8'h7F, 8'h03, 8'h00,
        8'hFF, 8'h00, 8'h05};
    logic [7:0] accVals[4] = '{8'h01, 8'h03, 8'h7F, 8'hFF};
    // Clock of 100 ns period
    always #50 clk = ~clk;
    datapath_model dp (.clk(clk), .opValid(opValid), .opCode(opCode),
        .opA(opA), .opB(opB), .carryIn(carryIn), .accumulator(acc));
    status_flag_update uut (.clk(clk), .reset_n(resetN), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datW),
        .dat_o(datR), .ack_o(ack), .opValid(opValid), .opCode(opCode),
        .opA(opA), .opB(opB), .carryIn(carryIn), .accumulator(acc),
        .overflowFlag(ovf), .userFlagOne(usr), .parityFlag(par),
        .bankSelectHigh(bHi), .bankSelectLow(bLo), .bankBase(bankBase),
        .statusWord(word), .opResult(res));
    // Closing report and verdict
    task automatic testDone();
        $display("Checks %0d, mismatches %0d", totalChecks, numErrors);
        if (numErrors == 0 && totalChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            numErrors++;
            testDone();
        end
    end
    // Classic single bus cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        datW <= d;
        @(posedge clk);
        while (ack !== 1'b1) begin
            @(posedge clk);
        end
        q = datR;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        #1;
    endtask
    // Overflow expected after an operation
    function automatic logic ovRule(op_type k, logic [7:0] a, logic [7:0] b,
                                    logic ci, logic prev);
        logic [8:0] s;
        case (k)
            ADD_OP, ADD_WITH_CARRY_OP: begin
                s = a + b + ((k == ADD_WITH_CARRY_OP) ? ci : 1'b0);
                return (a[7] == b[7]) && (s[7] != a[7]);
            end
            SUBTRACT_WITH_BORROW_OP: begin
                s = a - b - ci;
                return (a[7] != b[7]) && (s[7] != a[7]);
            end
            MULTIPLY_OP: return (16'(a) * 16'(b)) > 16'h00FF;
            DIVIDE_OP: return b == 8'h00;
            default: return prev;
        endcase
    endfunction
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        resetN <= 1'b1;
        wb(1'b0, 8'h00, 32'h0, rd);
        `CHK("status after reset", 32'h0000_0000, rd)
        wb(1'b1, 8'h08, 32'h0000_00FF, rd);
        wb(1'b0, 8'h08, 32'h0, rd);
        `CHK("unmapped read", 32'h0000_0000, rd)
        wb(1'b1, 8'h00, 32'h0000_0012, rd);
        `CHK("bank base 10", 5'h10, bankBase)
        `CHK("bank high", 1'b1, bHi)
        `CHK("bank low", 1'b0, bLo)
        wb(1'b1, 8'h00, 32'h0000_001B, rd);
        `CHK("bank base 11", 5'h18, bankBase)
        `CHK("bank low set", 1'b1, bLo)
        wb(1'b0, 8'h00, 32'h0, rd);
        `CHK("parity read only", 32'h0000_001A, rd)
        expOv = 1'b0;
        for (int i = 0; i < 10; i++) begin
            expOv = ovRule(tCode[i], tA[i], tB[i], tC[i], expOv);
            dp.issue(tCode[i], tA[i], tB[i], tC[i]);
            #1;
            `CHK("overflow", expOv, ovf)
            `CHK("user flag", 1'b1, usr)
            `CHK("op result", tR[i], res)
        end
        wb(1'b1, 8'h04, 32'h0000_0077, rd);
        wb(1'b0, 8'h04, 32'h0, rd);
        `CHK("last result", 32'h0000_0005, rd)
        foreach (accVals[i]) begin
            dp.setAcc(accVals[i]);
            @(posedge clk);
            #1;
            `CHK("parity", ^accVals[i], par)
        end
        wb(1'b0, 8'h00, 32'h0, rd);
        `CHK("status word", {27'h3, expOv, 1'b1, 1'b0}, rd)
        `CHK("status byte", 8'h1A, word)
        wb(1'b1, 8'h00, 32'h0, rd);
        `CHK("user flag clear", 1'b0, usr)
        `CHK("bank base 00", 5'h00, bankBase)
        testDone();
    end
endmodule
